// *** logic/cpu_register_file_control.sv ***
// Architectural register state: general registers, control registers, modes
`timescale 1ns/100ps
module cpu_register_file_control #(
  parameter logic [31:0] PROCESSOR_ID = cpu_regs_pkg::PROCESSOR_ID_DEFAULT,
  parameter logic [31:0] EXC_HANDLER_ADDR = cpu_regs_pkg::EXC_HANDLER_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] gpr_rd_addr_a,
  input wire logic [4:0] gpr_rd_addr_b,
  output logic [31:0] gpr_rd_data_a,
  output logic [31:0] gpr_rd_data_b,
  input cpu_regs_pkg::gpr_write_t gpr_wr,
  input wire logic call_exec,
  input wire logic [31:0] call_link_addr,
  output logic [31:0] return_target,
  input wire logic [2:0] ctl_rd_idx,
  output logic [31:0] ctl_rd_data,
  input cpu_regs_pkg::ctl_write_t ctl_wr,
  input wire logic [31:0] irq,
  output logic int_request,
  input wire logic exc_take,
  input wire logic [31:0] exc_next_addr,
  output logic [31:0] exc_handler_addr,
  input wire logic eret_exec,
  output logic [31:0] eret_target,
  input wire logic break_instr,
  input wire logic hw_break,
  input wire logic [31:0] break_next_addr,
  input wire logic bret_exec,
  output logic debug_mode
);

  // ********************************************************************
  // Control register state
  // ********************************************************************
  logic global_int_enable;
  logic exc_saved_int_enable;
  logic brk_saved_int_enable;
  logic [31:0] interrupt_line_enable;
  logic next_global_int_enable;
  logic next_exc_saved_int_enable;
  logic next_brk_saved_int_enable;
  logic [31:0] next_interrupt_line_enable;
  logic [31:0] next_ctl_rd_data;
  logic [31:0] interrupt_pending;
  logic brk_take;
  logic bret_take;
  logic eret_take;
  logic ctl_event;
  cpu_regs_pkg::gpr_write_t gpr_wr_sel;

  function automatic logic [31:0] status_word(input logic bit0);
    status_word = {31'h0000_0000, bit0};
  endfunction

  function automatic logic ctl_hit(input cpu_regs_pkg::ctl_write_t w, input logic [2:0] idx);
    ctl_hit = w.en && (w.idx == idx);
  endfunction

  // ********************************************************************
  // Operating mode
  // ********************************************************************
  mode_fsm u_mode (
    .clk_sys(clk_sys),
    .rst(rst),
    .enter_req(break_instr | hw_break),
    .exit_req(bret_exec),
    .debug_mode(debug_mode),
    .enter_take(brk_take),
    .exit_take(bret_take)
  );

  // Exception entry outranks a same-cycle exception return; a break or break return is still taken
  assign eret_take = eret_exec && !exc_take;

  // An exception, exception return, break or break return drops a control write in that cycle; a call does not
  assign ctl_event = exc_take || eret_take || brk_take || bret_take;

  // ********************************************************************
  // General register write steering
  // ********************************************************************
  always_comb begin
    gpr_wr_sel = gpr_wr;
    if (exc_take) begin
      gpr_wr_sel.en = 1'b1;
      gpr_wr_sel.addr = cpu_regs_pkg::EXCEPTION_RETURN_REG;
      gpr_wr_sel.data = exc_next_addr;
    end else if (brk_take) begin
      gpr_wr_sel.en = 1'b1;
      gpr_wr_sel.addr = cpu_regs_pkg::BREAK_RETURN_REG;
      gpr_wr_sel.data = break_next_addr;
    end else if (call_exec) begin
      gpr_wr_sel.en = 1'b1;
      gpr_wr_sel.addr = cpu_regs_pkg::RETURN_ADDRESS_REG;
      gpr_wr_sel.data = call_link_addr;
    end
  end

  gpr_bank u_gpr (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr(gpr_wr_sel),
    .rd_addr_a(gpr_rd_addr_a),
    .rd_addr_b(gpr_rd_addr_b),
    .rd_data_a(gpr_rd_data_a),
    .rd_data_b(gpr_rd_data_b),
    .return_address_q(return_target),
    .exception_return_q(eret_target)
  );

  assign exc_handler_addr = EXC_HANDLER_ADDR;

  // ********************************************************************
  // Interrupt gating
  // ********************************************************************
  assign interrupt_pending = irq & interrupt_line_enable;
  assign int_request = global_int_enable && (|interrupt_pending) && !debug_mode;

  // ********************************************************************
  // Control register update, exception and break copies
  // ********************************************************************
  always_comb begin
    next_global_int_enable = global_int_enable;
    next_exc_saved_int_enable = exc_saved_int_enable;
    next_brk_saved_int_enable = brk_saved_int_enable;
    next_interrupt_line_enable = interrupt_line_enable;
    if (exc_take) begin
      next_exc_saved_int_enable = global_int_enable;
      next_global_int_enable = 1'b0;
    end else if (eret_take) begin
      next_global_int_enable = exc_saved_int_enable;
    end else if (brk_take) begin
      next_brk_saved_int_enable = global_int_enable;
    end else if (bret_take) begin
      next_global_int_enable = brk_saved_int_enable;
    end else begin
      // Only bit 0 of the status registers is kept; ids 4 and 5 ignore writes
      if (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_PROCESSOR_STATUS)) begin
        next_global_int_enable = ctl_wr.data[cpu_regs_pkg::INT_ENABLE_BIT];
      end
      if (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_EXCEPTION_SAVED_STATUS)) begin
        next_exc_saved_int_enable = ctl_wr.data[cpu_regs_pkg::INT_ENABLE_BIT];
      end
      if (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_BREAK_SAVED_STATUS)) begin
        next_brk_saved_int_enable = ctl_wr.data[cpu_regs_pkg::INT_ENABLE_BIT];
      end
      if (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_INTERRUPT_LINE_ENABLE)) begin
        next_interrupt_line_enable = ctl_wr.data;
      end
    end
    // A break that meets an exception or return still saves the old status
    if (brk_take) begin
      next_brk_saved_int_enable = global_int_enable;
    end
  end

  // ********************************************************************
  // Control register read
  // ********************************************************************
  always_comb begin
    case (ctl_rd_idx)
      cpu_regs_pkg::CTL_PROCESSOR_STATUS: begin
        next_ctl_rd_data = status_word(global_int_enable);
      end
      cpu_regs_pkg::CTL_EXCEPTION_SAVED_STATUS: begin
        next_ctl_rd_data = status_word(exc_saved_int_enable);
      end
      cpu_regs_pkg::CTL_BREAK_SAVED_STATUS: begin
        next_ctl_rd_data = status_word(brk_saved_int_enable);
      end
      cpu_regs_pkg::CTL_INTERRUPT_LINE_ENABLE: begin
        next_ctl_rd_data = interrupt_line_enable;
      end
      cpu_regs_pkg::CTL_INTERRUPT_PENDING: begin
        next_ctl_rd_data = interrupt_pending;
      end
      cpu_regs_pkg::CTL_PROCESSOR_IDENTIFIER: begin
        next_ctl_rd_data = PROCESSOR_ID;
      end
      default: begin
        next_ctl_rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      global_int_enable <= cpu_regs_pkg::STATUS_RESET;
      exc_saved_int_enable <= cpu_regs_pkg::STATUS_RESET;
      brk_saved_int_enable <= cpu_regs_pkg::STATUS_RESET;
      interrupt_line_enable <= cpu_regs_pkg::LINE_ENABLE_RESET;
      ctl_rd_data <= 32'h0000_0000;
    end else begin
      global_int_enable <= next_global_int_enable;
      exc_saved_int_enable <= next_exc_saved_int_enable;
      brk_saved_int_enable <= next_brk_saved_int_enable;
      interrupt_line_enable <= next_interrupt_line_enable;
      ctl_rd_data <= next_ctl_rd_data;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_break_enter;
    brk_take ##1 debug_mode;
  endsequence

  sequence s_break_leave;
    bret_take ##1 !debug_mode;
  endsequence

  a_zero_reads:
    assert property (gpr_rd_addr_a == cpu_regs_pkg::REG_ZERO |=> gpr_rd_data_a == 32'h0)
    else $error("register zero read nonzero");

  a_call_link:
    assert property (call_exec && !exc_take && !brk_take
      |-> ##2 return_target == $past(call_link_addr, 2))
    else $error("call link address not in return register");

  a_exc_entry:
    assert property (exc_take |=> !global_int_enable
      && exc_saved_int_enable == $past(global_int_enable))
    else $error("exception entry did not save and clear enable");

  a_eret_restore:
    assert property (eret_take |=> global_int_enable == $past(exc_saved_int_enable))
    else $error("exception return did not restore enable");

  a_break_save:
    assert property (brk_take |-> s_break_enter
      and (##1 brk_saved_int_enable == $past(global_int_enable)))
    else $error("break did not save status");

  a_debug_restore:
    assert property (bret_take && !exc_take |-> s_break_leave
      and (##1 global_int_enable == $past(brk_saved_int_enable)))
    else $error("leaving debug did not restore status");

  a_debug_entry_cause:
    assert property (!debug_mode && !break_instr && !hw_break |=> !debug_mode)
    else $error("debug mode entered without a break");

  a_irq_gate:
    assert property (!global_int_enable |-> !int_request)
    else $error("interrupt requested while disabled");

  a_pending_read:
    assert property (ctl_rd_idx == cpu_regs_pkg::CTL_INTERRUPT_PENDING
      |=> ctl_rd_data == $past(irq & interrupt_line_enable))
    else $error("pending read mismatch");

  a_ident_read:
    assert property (ctl_rd_idx == cpu_regs_pkg::CTL_PROCESSOR_IDENTIFIER
      |=> ctl_rd_data == PROCESSOR_ID)
    else $error("identifier read mismatch");

  a_reserved_zero:
    assert property (ctl_rd_idx <= cpu_regs_pkg::CTL_BREAK_SAVED_STATUS
      |=> ctl_rd_data[31:1] == 31'h0)
    else $error("reserved status bits nonzero");

  a_status_write:
    assert property (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_PROCESSOR_STATUS) && !ctl_event
      |=> global_int_enable == $past(ctl_wr.data[cpu_regs_pkg::INT_ENABLE_BIT]))
    else $error("status write not applied");

  a_line_enable_write:
    assert property (ctl_hit(ctl_wr, cpu_regs_pkg::CTL_INTERRUPT_LINE_ENABLE) && !ctl_event
      |=> interrupt_line_enable == $past(ctl_wr.data))
    else $error("line enable write not applied");

  a_exc_link:
    assert property (exc_take
      |-> ##2 eret_target == $past(exc_next_addr, 2))
    else $error("exception link address not in return register");

  a_reset_state:
    assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> !debug_mode && !global_int_enable)
    else $error("reset state wrong");

endmodule

// *** logic/cpu_regs_pkg.sv ***
// Shared constants and carrier types for the processor register state
package cpu_regs_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int XLEN = 32;
  localparam int NUM_GPR = 32;
  localparam int GPR_AW = 5;
  localparam int CTL_AW = 3;

  // ********************************************************************
  // General register numbers with a fixed role
  // ********************************************************************
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] EXCEPTION_TEMP_REG = 5'h18;
  localparam logic [4:0] BREAKPOINT_TEMP_REG = 5'h19;
  localparam logic [4:0] EXCEPTION_RETURN_REG = 5'h1d;
  localparam logic [4:0] BREAK_RETURN_REG = 5'h1e;
  localparam logic [4:0] RETURN_ADDRESS_REG = 5'h1f;

  // ********************************************************************
  // Control register indices and fields
  // ********************************************************************
  localparam logic [2:0] CTL_PROCESSOR_STATUS = 3'h0;
  localparam logic [2:0] CTL_EXCEPTION_SAVED_STATUS = 3'h1;
  localparam logic [2:0] CTL_BREAK_SAVED_STATUS = 3'h2;
  localparam logic [2:0] CTL_INTERRUPT_LINE_ENABLE = 3'h3;
  localparam logic [2:0] CTL_INTERRUPT_PENDING = 3'h4;
  localparam logic [2:0] CTL_PROCESSOR_IDENTIFIER = 3'h5;
  localparam int INT_ENABLE_BIT = 0;

  // ********************************************************************
  // Reset values and generation-time constants
  // ********************************************************************
  localparam logic STATUS_RESET = 1'b0;
  localparam logic [31:0] LINE_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  // Arbitrary value, replaced at system generation
  localparam logic [31:0] PROCESSOR_ID_DEFAULT = 32'h0000_0001;
  localparam logic [31:0] EXC_HANDLER_DEFAULT = 32'h0000_0020;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [31:0] data;
  } gpr_write_t;

  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [31:0] data;
  } ctl_write_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b01,
    MODE_DEBUG = 2'b10
  } mode_t;

endpackage

// *** logic/gpr_bank.sv ***
// Thirty-two general registers with registered reads and a zero register
`timescale 1ns/100ps
module gpr_bank (
  input wire logic clk_sys,
  input wire logic rst,
  input cpu_regs_pkg::gpr_write_t wr,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [31:0] return_address_q,
  output logic [31:0] exception_return_q
);

  logic [31:0] regs [cpu_regs_pkg::NUM_GPR];
  logic [31:0] next_regs [cpu_regs_pkg::NUM_GPR];
  logic [31:0] next_rd_data_a;
  logic [31:0] next_rd_data_b;

  always_comb begin
    for (int i = 0; i < cpu_regs_pkg::NUM_GPR; i++) begin
      next_regs[i] = regs[i];
    end
    if (wr.en && wr.addr != cpu_regs_pkg::REG_ZERO) begin
      next_regs[wr.addr] = wr.data;
    end
    next_regs[cpu_regs_pkg::REG_ZERO] = cpu_regs_pkg::GPR_RESET;
    next_rd_data_a = regs[rd_addr_a];
    next_rd_data_b = regs[rd_addr_b];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < cpu_regs_pkg::NUM_GPR; i++) begin
        regs[i] <= cpu_regs_pkg::GPR_RESET;
      end
      rd_data_a <= cpu_regs_pkg::GPR_RESET;
      rd_data_b <= cpu_regs_pkg::GPR_RESET;
      return_address_q <= cpu_regs_pkg::GPR_RESET;
      exception_return_q <= cpu_regs_pkg::GPR_RESET;
    end else begin
      for (int i = 0; i < cpu_regs_pkg::NUM_GPR; i++) begin
        regs[i] <= next_regs[i];
      end
      rd_data_a <= next_rd_data_a;
      rd_data_b <= next_rd_data_b;
      return_address_q <= regs[cpu_regs_pkg::RETURN_ADDRESS_REG];
      exception_return_q <= regs[cpu_regs_pkg::EXCEPTION_RETURN_REG];
    end
  end

endmodule

// *** logic/mode_fsm.sv ***
// Normal and debug operating mode tracker
`timescale 1ns/100ps
module mode_fsm (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enter_req,
  input wire logic exit_req,
  output logic debug_mode,
  output logic enter_take,
  output logic exit_take
);

  cpu_regs_pkg::mode_t state;
  cpu_regs_pkg::mode_t next_state;

  always_comb begin
    next_state = state;
    enter_take = 1'b0;
    exit_take = 1'b0;
    case (state)
      cpu_regs_pkg::MODE_NORMAL: begin
        if (enter_req) begin
          enter_take = 1'b1;
          next_state = cpu_regs_pkg::MODE_DEBUG;
        end
      end
      cpu_regs_pkg::MODE_DEBUG: begin
        if (exit_req) begin
          exit_take = 1'b1;
          next_state = cpu_regs_pkg::MODE_NORMAL;
        end
      end
      default: begin
        next_state = cpu_regs_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= cpu_regs_pkg::MODE_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  assign debug_mode = (state == cpu_regs_pkg::MODE_DEBUG);

endmodule

// *** verification/exec_debug_model.sv ***
// Stand-in for the execution datapath and debug module driving the register block
`timescale 1ns/100ps
module exec_debug_model (
  input wire logic clk_sys,
  output logic [4:0] gpr_rd_addr_a,
  output logic [4:0] gpr_rd_addr_b,
  output cpu_regs_pkg::gpr_write_t gpr_wr,
  output logic call_exec,
  output logic [31:0] call_link_addr,
  output logic [2:0] ctl_rd_idx,
  output cpu_regs_pkg::ctl_write_t ctl_wr,
  output logic [31:0] irq,
  output logic exc_take,
  output logic [31:0] exc_next_addr,
  output logic eret_exec,
  output logic break_instr,
  output logic hw_break,
  output logic [31:0] break_next_addr,
  output logic bret_exec
);
  initial begin
    gpr_rd_addr_a = 5'h00;
    gpr_rd_addr_b = 5'h00;
    gpr_wr = '0;
    ctl_rd_idx = 3'h0;
    ctl_wr = '0;
    irq = 32'h0000_0000;
    exc_next_addr = 32'h0000_0000;
    call_link_addr = 32'h0000_0000;
    break_next_addr = 32'h0000_0000;
    {exc_take, eret_exec, break_instr, hw_break, bret_exec, call_exec} = 6'h00;
  end

  task automatic gw(input logic [4:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    gpr_wr = '{en: 1'b1, addr: a, data: d};
    @(negedge clk_sys);
    gpr_wr.en = 1'b0;
  endtask

  task automatic cw(input logic [2:0] i, input logic [31:0] d);
    @(negedge clk_sys);
    ctl_wr = '{en: 1'b1, idx: i, data: d};
    @(negedge clk_sys);
    ctl_wr.en = 1'b0;
  endtask

  // Data of the selected registers is settled at the negedge this returns on
  task automatic rd(input logic [4:0] g, input logic [2:0] c);
    @(negedge clk_sys);
    gpr_rd_addr_a = g;
    gpr_rd_addr_b = g;
    ctl_rd_idx = c;
    @(negedge clk_sys);
  endtask

  task automatic set_irq(input logic [31:0] v);
    @(negedge clk_sys);
    irq = v;
    @(negedge clk_sys);
  endtask

  // One-cycle event: 0 exception, 1 eret, 2 break, 3 hw break, 4 bret, 5 call
  task automatic ev(input int k, input logic [31:0] a);
    @(negedge clk_sys);
    exc_next_addr = a;
    call_link_addr = a;
    break_next_addr = a;
    exc_take = (k == 0);
    eret_exec = (k == 1);
    break_instr = (k == 2);
    hw_break = (k == 3);
    bret_exec = (k == 4);
    call_exec = (k == 5);
    @(negedge clk_sys);
    {exc_take, eret_exec, break_instr, hw_break, bret_exec, call_exec} = 6'h00;
    @(negedge clk_sys);
  endtask
endmodule

// *** verification/cpu_register_file_control_test.sv ***
// Self-checking bench for the processor register state block
`timescale 1ns/100ps
module cpu_register_file_control_test;
  // Arbitrary identifier value
  localparam logic [31:0] ID = 32'h0000_00c3;
  localparam logic [31:0] HND = 32'h0000_0100;
  typedef struct packed {
    logic ctl;
    logic [4:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_t;
  localparam row_t ROWS [12] = '{
    '{1'b0, 5'h00, 32'hffff_ffff, 32'h0000_0000},
    '{1'b0, 5'h01, 32'h1234_5678, 32'h1234_5678},
    '{1'b0, 5'h1f, 32'h0000_a5a5, 32'h0000_a5a5},
    '{1'b0, 5'h19, 32'h0000_0019, 32'h0000_0019},
    '{1'b0, 5'h1e, 32'h0000_001e, 32'h0000_001e},
    '{1'b1, 5'h00, 32'hffff_ffff, 32'h0000_0001},
    '{1'b1, 5'h01, 32'hffff_ffff, 32'h0000_0001},
    '{1'b1, 5'h02, 32'hffff_ffff, 32'h0000_0001},
    '{1'b1, 5'h03, 32'h5a5a_5a5a, 32'h5a5a_5a5a},
    '{1'b1, 5'h04, 32'hffff_ffff, 32'h0000_0000},
    '{1'b1, 5'h05, 32'hffff_ffff, ID},
    '{1'b1, 5'h06, 32'hffff_ffff, 32'h0000_0000}
  };
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] gpr_rd_addr_a, gpr_rd_addr_b;
  logic [31:0] gpr_rd_data_a, gpr_rd_data_b, call_link_addr, return_target, ctl_rd_data, irq;
  logic [31:0] exc_next_addr, exc_handler_addr, eret_target, break_next_addr;
  cpu_regs_pkg::gpr_write_t gpr_wr;
  cpu_regs_pkg::ctl_write_t ctl_wr;
  logic [2:0] ctl_rd_idx;
  logic call_exec, int_request, exc_take, eret_exec, break_instr, hw_break, bret_exec;
  logic debug_mode;
  int fail_count = 0;
  int checks = 0;

  always #2 clk_sys = ~clk_sys;

  exec_debug_model model (.clk_sys, .gpr_rd_addr_a, .gpr_rd_addr_b, .gpr_wr, .call_exec,
    .call_link_addr, .ctl_rd_idx, .ctl_wr, .irq, .exc_take, .exc_next_addr, .eret_exec,
    .break_instr, .hw_break, .break_next_addr, .bret_exec);

  cpu_register_file_control #(.PROCESSOR_ID(ID), .EXC_HANDLER_ADDR(HND)) dut (.clk_sys, .rst,
    .gpr_rd_addr_a, .gpr_rd_addr_b, .gpr_rd_data_a, .gpr_rd_data_b, .gpr_wr, .call_exec,
    .call_link_addr, .return_target, .ctl_rd_idx, .ctl_rd_data, .ctl_wr, .irq, .int_request,
    .exc_take, .exc_next_addr, .exc_handler_addr, .eret_exec, .eret_target, .break_instr,
    .hw_break, .break_next_addr, .bret_exec, .debug_mode);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    model.rd(5'h00, 3'h0);
    chk(ctl_rd_data, 32'h0000_0000);
    chk(32'(debug_mode), 32'h0000_0000);
    chk(32'(int_request), 32'h0000_0000);
    $display("test reset done");
    // ****************************************************************
    // Table of writes and read-backs
    // ****************************************************************
    foreach (ROWS[i]) begin
      if (ROWS[i].ctl) begin
        if (ROWS[i].a[2:0] != cpu_regs_pkg::CTL_INTERRUPT_PENDING) begin
          model.cw(ROWS[i].a[2:0], ROWS[i].w);
        end
        model.rd(5'h00, ROWS[i].a[2:0]);
        chk(ctl_rd_data, ROWS[i].e);
      end else begin
        model.gw(ROWS[i].a, ROWS[i].w);
        model.rd(ROWS[i].a, 3'h0);
        chk(gpr_rd_data_a, ROWS[i].e);
        chk(gpr_rd_data_b, ROWS[i].e);
      end
    end
    chk(32'(debug_mode), 32'h0000_0000);
    $display("test table done");
    // ****************************************************************
    // Interrupt gating
    // ****************************************************************
    model.cw(3'h0, 32'h0000_0000);
    model.cw(3'h3, 32'h0000_0005);
    model.set_irq(32'h0000_0006);
    model.rd(5'h00, 3'h4);
    chk(ctl_rd_data, 32'h0000_0004);
    chk(32'(int_request), 32'h0000_0000);
    model.cw(3'h0, 32'h0000_0001);
    chk(32'(int_request), 32'h0000_0001);
    model.set_irq(32'h0000_0002);
    chk(32'(int_request), 32'h0000_0000);
    model.set_irq(32'h0000_0000);
    $display("test interrupts done");
    // ****************************************************************
    // Exception entry and return, call link
    // ****************************************************************
    model.ev(0, 32'h0000_1234);
    model.rd(5'h1d, 3'h0);
    chk(ctl_rd_data, 32'h0000_0000);
    chk(gpr_rd_data_a, 32'h0000_1234);
    model.rd(5'h00, 3'h1);
    chk(ctl_rd_data, 32'h0000_0001);
    chk(exc_handler_addr, HND);
    chk(eret_target, 32'h0000_1234);
    model.ev(1, 32'h0000_0000);
    model.rd(5'h00, 3'h0);
    chk(ctl_rd_data, 32'h0000_0001);
    model.ev(5, 32'h0000_4444);
    chk(return_target, 32'h0000_4444);
    model.rd(5'h1f, 3'h0);
    chk(gpr_rd_data_a, 32'h0000_4444);
    $display("test exception done");
    // ****************************************************************
    // Debug entry by instruction and by hardware, then exit
    // ****************************************************************
    model.ev(2, 32'h0000_3000);
    chk(32'(debug_mode), 32'h0000_0001);
    model.rd(5'h1e, 3'h2);
    chk(gpr_rd_data_a, 32'h0000_3000);
    chk(ctl_rd_data, 32'h0000_0001);
    model.cw(3'h0, 32'h0000_0000);
    model.ev(4, 32'h0000_0000);
    chk(32'(debug_mode), 32'h0000_0000);
    model.rd(5'h00, 3'h0);
    chk(ctl_rd_data, 32'h0000_0001);
    model.cw(3'h0, 32'h0000_0000);
    model.ev(3, 32'h0000_3100);
    chk(32'(debug_mode), 32'h0000_0001);
    model.rd(5'h1e, 3'h2);
    chk(ctl_rd_data, 32'h0000_0000);
    chk(gpr_rd_data_a, 32'h0000_3100);
    model.ev(4, 32'h0000_0000);
    model.ev(4, 32'h0000_0000);
    chk(32'(debug_mode), 32'h0000_0000);
    $display("test debug done");
    // ****************************************************************
    // Reset in mid-run, from debug mode with interrupts enabled
    // ****************************************************************
    model.cw(3'h0, 32'h0000_0001);
    model.ev(2, 32'h0000_3200);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(32'(debug_mode), 32'h0000_0000);
    model.rd(5'h1e, 3'h0);
    chk(ctl_rd_data, 32'h0000_0000);
    chk(gpr_rd_data_a, 32'h0000_0000);
    $display("test reset again done");
    end_sim();
  end
endmodule
